// ---- hw/sfpi_pins.sv ----
// Purpose: pin-level serial interface of a multi-line serial flash (target side)
// Assumes: CLK well above the serial clock; decoder supplies phase width and direction
// Notes: all pins pass two flops; serial clock edges are found by comparing samples
`timescale 1ns/1ns
`default_nettype none

module sfpi_pins
    import sfpi_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCLK_PIN,
    input wire logic SEL_N_PIN,
    input wire logic RESET_N_PIN,
    input wire logic [3:0] DQ_IN,
    output sfpi_drive_t DQ_DRIVE,
    output logic [3:0] DQ_IE,
    input wire sfpi_proto_t PROTOCOL,
    input wire sfpi_xfer_t XFER,
    input wire logic PAUSE_ENABLE,
    input wire logic DQ3_RESET_ENABLE,
    input wire logic BOOST_SUPPLY_HIGH,
    input wire logic BUSY,
    input wire logic [7:0] TX_DATA,
    output logic TX_TAKEN,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    output logic FRAME_START,
    output logic FRAME_END,
    output logic ARMED,
    output logic PAUSED,
    output logic ACTIVE_POWER,
    output logic STANDBY_POWER,
    output logic IN_RESET,
    output sfpi_proto_t PROTOCOL_IN_USE
);

    // two stage synchroniser; stage one feeds stage two only
    sfpi_pins_t meta;
    sfpi_pins_t pins;
    sfpi_pins_t pins_prev;

    always_ff @(posedge CLK) begin
        if (RST) begin
            meta <= SFPI_PINS_RESET;
            pins <= SFPI_PINS_RESET;
            pins_prev <= SFPI_PINS_RESET;
        end else begin
            meta <= '{sclk: SCLK_PIN, sel_n: SEL_N_PIN, reset_n: RESET_N_PIN, dq: DQ_IN};
            pins <= meta;
            pins_prev <= pins;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;
    sfpi_proto_t proto_eff;
    sfpi_width_t width_eff;
    logic quad_lines;
    logic hold_req;
    logic hw_reset;
    logic [3:0] step;

    always_comb begin
        sclk_rise = pins.sclk & ~pins_prev.sclk;
        sclk_fall = ~pins.sclk & pins_prev.sclk;
        // the reset sample of sel_n is low, so select held low through reset gives no fall
        sel_fall = ~pins.sel_n & pins_prev.sel_n;
        sel_rise = pins.sel_n & ~pins_prev.sel_n;
        // boosted program or erase in quad runs on the single line protocol
        if (PROTOCOL == SFPI_PROTO_QUAD && BOOST_SUPPLY_HIGH) begin
            proto_eff = SFPI_PROTO_SINGLE;
        end else begin
            proto_eff = PROTOCOL;
        end
        case (proto_eff)
            SFPI_PROTO_DUAL: width_eff = SFPI_W2;
            SFPI_PROTO_QUAD: width_eff = SFPI_W4;
            default: width_eff = XFER.width;
        endcase
        case (width_eff)
            SFPI_W2: step = SFPI_STEP_W2;
            SFPI_W4: step = SFPI_STEP_W4;
            default: step = SFPI_STEP_W1;
        endcase
        // line 3 is data whenever quad lines are in use
        quad_lines = (proto_eff == SFPI_PROTO_QUAD) || (width_eff == SFPI_W4);
        hold_req = PAUSE_ENABLE && !pins.sel_n && !quad_lines && !pins.dq[3];
        // line 3 reset meaning only counts while deselected
        hw_reset = !pins.reset_n || (DQ3_RESET_ENABLE && pins.sel_n && !pins.dq[3]);
    end

    sfpi_state_t state;
    sfpi_state_t next_state;
    logic armed;
    logic next_armed;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [3:0] rx_cnt;
    logic [3:0] next_rx_cnt;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    sfpi_drive_t drive;
    sfpi_drive_t next_drive;
    logic [3:0] next_ie;
    logic next_tx_taken;
    logic [7:0] next_rx_data;
    logic next_rx_valid;
    logic next_frame_start;
    logic next_frame_end;
    logic [7:0] tx_word;
    logic [3:0] lane_mask;

    always_comb begin
        next_state = state;
        next_armed = armed;
        next_rx_shift = rx_shift;
        next_rx_cnt = rx_cnt;
        next_tx_shift = tx_shift;
        next_tx_cnt = tx_cnt;
        next_drive = drive;
        next_tx_taken = 1'b0;
        next_rx_data = RX_DATA;
        next_rx_valid = 1'b0;
        next_frame_start = 1'b0;
        next_frame_end = 1'b0;
        tx_word = tx_shift;
        case (width_eff)
            SFPI_W2: lane_mask = 4'h3;
            SFPI_W4: lane_mask = 4'hF;
            default: lane_mask = 4'h2;
        endcase
        case (state)
            SFPI_ST_RESET: begin
                next_drive = SFPI_DRIVE_RESET;
                if (!hw_reset) begin
                    next_state = SFPI_ST_IDLE;
                end
            end
            SFPI_ST_IDLE: begin
                next_drive = SFPI_DRIVE_RESET;
                next_rx_cnt = SFPI_CNT_RESET;
                next_tx_cnt = SFPI_CNT_RESET;
                if (sel_fall) begin
                    next_armed = 1'b1;
                    next_state = SFPI_ST_FRAME;
                    next_frame_start = 1'b1;
                end
            end
            SFPI_ST_FRAME: begin
                if (sel_rise || pins.sel_n) begin
                    next_state = SFPI_ST_IDLE;
                    next_drive = SFPI_DRIVE_RESET;
                    next_frame_end = 1'b1;
                end else if (hold_req) begin
                    next_state = SFPI_ST_PAUSE;
                    next_drive.oe = 4'h0;
                end else begin
                    if (sclk_rise && !XFER.dir_out) begin
                        case (width_eff)
                            SFPI_W2: next_rx_shift = {rx_shift[5:0], pins.dq[1:0]};
                            SFPI_W4: next_rx_shift = {rx_shift[3:0], pins.dq};
                            default: next_rx_shift = {rx_shift[6:0], pins.dq[0]};
                        endcase
                        if (rx_cnt + step >= SFPI_BYTE_BITS) begin
                            next_rx_cnt = SFPI_CNT_RESET;
                            next_rx_data = next_rx_shift;
                            next_rx_valid = 1'b1;
                        end else begin
                            next_rx_cnt = rx_cnt + step;
                        end
                    end
                    if (sclk_fall && XFER.dir_out) begin
                        // a fresh byte is fetched when the previous one has gone
                        if (tx_cnt == SFPI_CNT_RESET) begin
                            tx_word = TX_DATA;
                            next_tx_taken = 1'b1;
                        end
                        case (width_eff)
                            SFPI_W2: next_drive.dout = {2'b00, tx_word[7:6]};
                            SFPI_W4: next_drive.dout = tx_word[7:4];
                            default: next_drive.dout = {2'b00, tx_word[7], 1'b0};
                        endcase
                        next_tx_shift = tx_word << step;
                        next_drive.oe = lane_mask;
                        if (tx_cnt + step >= SFPI_BYTE_BITS) begin
                            next_tx_cnt = SFPI_CNT_RESET;
                        end else begin
                            next_tx_cnt = tx_cnt + step;
                        end
                    end
                    if (!XFER.dir_out) begin
                        next_drive.oe = 4'h0;
                        next_tx_cnt = SFPI_CNT_RESET;
                    end
                end
            end
            SFPI_ST_PAUSE: begin
                // clock and input data are ignored; the frame position is kept
                next_drive.oe = 4'h0;
                if (pins.sel_n) begin
                    next_state = SFPI_ST_IDLE;
                    next_frame_end = 1'b1;
                end else if (!hold_req) begin
                    next_state = SFPI_ST_FRAME;
                end
            end
            default: begin
                next_state = SFPI_ST_IDLE;
                next_drive = SFPI_DRIVE_RESET;
            end
        endcase
        if (hw_reset) begin
            next_state = SFPI_ST_RESET;
            next_drive = SFPI_DRIVE_RESET;
            next_rx_cnt = SFPI_CNT_RESET;
            next_tx_cnt = SFPI_CNT_RESET;
            next_tx_taken = 1'b0;
            next_rx_valid = 1'b0;
            next_frame_start = 1'b0;
        end
        // a receiver listens on every line not being driven
        next_ie = ~next_drive.oe;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= SFPI_ST_IDLE;
            armed <= 1'b0;
            rx_shift <= SFPI_BYTE_RESET;
            rx_cnt <= SFPI_CNT_RESET;
            tx_shift <= SFPI_BYTE_RESET;
            tx_cnt <= SFPI_CNT_RESET;
            drive <= SFPI_DRIVE_RESET;
            DQ_IE <= 4'hF;
            TX_TAKEN <= 1'b0;
            RX_DATA <= SFPI_BYTE_RESET;
            RX_VALID <= 1'b0;
            FRAME_START <= 1'b0;
            FRAME_END <= 1'b0;
        end else begin
            state <= next_state;
            armed <= next_armed;
            rx_shift <= next_rx_shift;
            rx_cnt <= next_rx_cnt;
            tx_shift <= next_tx_shift;
            tx_cnt <= next_tx_cnt;
            drive <= next_drive;
            DQ_IE <= next_ie;
            TX_TAKEN <= next_tx_taken;
            RX_DATA <= next_rx_data;
            RX_VALID <= next_rx_valid;
            FRAME_START <= next_frame_start;
            FRAME_END <= next_frame_end;
        end
    end

    assign DQ_DRIVE = drive;
    assign ARMED = armed;

    // power state; deselection never reaches deep power-down
    logic next_active;
    logic next_standby;
    logic next_paused;
    logic next_in_reset;

    always_comb begin
        next_active = (next_state == SFPI_ST_FRAME) || (next_state == SFPI_ST_PAUSE);
        next_standby = (next_state == SFPI_ST_IDLE) && !BUSY;
        next_paused = next_state == SFPI_ST_PAUSE;
        next_in_reset = next_state == SFPI_ST_RESET;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ACTIVE_POWER <= 1'b0;
            STANDBY_POWER <= 1'b0;
            PAUSED <= 1'b0;
            IN_RESET <= 1'b0;
            PROTOCOL_IN_USE <= SFPI_PROTO_SINGLE;
        end else begin
            ACTIVE_POWER <= next_active;
            STANDBY_POWER <= next_standby;
            PAUSED <= next_paused;
            IN_RESET <= next_in_reset;
            PROTOCOL_IN_USE <= proto_eff;
        end
    end

endmodule : sfpi_pins

`default_nettype wire

// ---- hw/sfpi_pkg.sv ----
// Purpose: shared types and constants for the serial flash pin interface
// Assumes: one system clock that oversamples the serial clock several times over
// Notes: line widths and protocol codes are shared with the command decoder
package sfpi_pkg;

    // protocol chosen by configuration
    typedef enum logic [1:0] {
        SFPI_PROTO_SINGLE = 2'h0,
        SFPI_PROTO_DUAL = 2'h1,
        SFPI_PROTO_QUAD = 2'h2
    } sfpi_proto_t;

    // number of data lines used in the current phase
    typedef enum logic [1:0] {
        SFPI_W1 = 2'h0,
        SFPI_W2 = 2'h1,
        SFPI_W4 = 2'h2
    } sfpi_width_t;

    // gray coded along idle -> frame -> pause, reset off to the side
    typedef enum logic [1:0] {
        SFPI_ST_IDLE = 2'h0,
        SFPI_ST_FRAME = 2'h1,
        SFPI_ST_PAUSE = 2'h3,
        SFPI_ST_RESET = 2'h2
    } sfpi_state_t;

    // drive of the four data lines
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } sfpi_drive_t;

    // phase description given by the command decoder
    typedef struct packed {
        sfpi_width_t width;
        logic dir_out;
    } sfpi_xfer_t;

    // synchronised copies of the pins
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic reset_n;
        logic [3:0] dq;
    } sfpi_pins_t;

    localparam int SFPI_LINES = 4;
    localparam logic [3:0] SFPI_BYTE_BITS = 4'h8;
    localparam logic [3:0] SFPI_STEP_W1 = 4'h1;
    localparam logic [3:0] SFPI_STEP_W2 = 4'h2;
    localparam logic [3:0] SFPI_STEP_W4 = 4'h4;
    localparam logic [7:0] SFPI_BYTE_RESET = 8'h00;
    localparam logic [3:0] SFPI_CNT_RESET = 4'h0;
    localparam sfpi_drive_t SFPI_DRIVE_RESET = '{dout: 4'h0, oe: 4'h0};
    localparam sfpi_pins_t SFPI_PINS_RESET = '{sclk: 1'b0, sel_n: 1'b0, reset_n: 1'b1,
                                               dq: 4'hF};

endpackage : sfpi_pkg

// ---- sim/sfpi_host.sv ----
// Purpose: host controller model for clock, select and data lines
// Assumes: half serial period is four CLK, changes land 1 ns after CLK rise
// Notes: serial clock stands low outside frames
`timescale 1ns/1ns
`default_nettype none
module sfpi_host (
    input wire logic clk,
    input wire logic [3:0] dq,
    output logic sclk,
    output logic sel_n,
    output logic [3:0] dout,
    output logic [3:0] oe
);
    task automatic init;
        sclk = 1'b0;
        sel_n = 1'b1;
        dout = 4'h0;
        oe = 4'h0;
    endtask : init

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic sel(input logic v);
        step(4);
        sel_n = v;
        // lines are let go at deselect, so back-to-back transfers never glitch the enable
        if (v) begin
            oe = 4'h0;
        end
        step(4);
    endtask : sel

    task automatic xfer(input int w, input logic rd, input logic [7:0] tx,
                        output logic [7:0] rx);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        rx = 8'h00;
        for (int i = 8 - w; i >= 0; i -= w) begin
            oe = rd ? 4'h0 : m;
            dout = 4'(tx >> i);
            step(4);
            sclk = 1'b1;
            // single-line reads come back on line 1 only
            rx = (rx << w) | 8'(w == 1 ? {3'h0, dq[1]} : dq & m);
            step(4);
            sclk = 1'b0;
        end
    endtask : xfer
endmodule : sfpi_host
`default_nettype wire

// ---- sim/sfpi_props.sv ----
// Purpose: port checker for sfpi_pins
// Assumes: pins pass two sync flops plus a register, so pin rules allow six CLK, the standby rule eight
// Notes: bound at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module sfpi_props
    import sfpi_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic SEL_N_PIN,
    input wire logic RESET_N_PIN,
    input wire sfpi_proto_t PROTOCOL,
    input wire logic BOOST_SUPPLY_HIGH,
    input wire logic BUSY,
    input wire logic DQ3_RESET_ENABLE,
    input wire logic [3:0] DQ_IN,
    input wire sfpi_drive_t DQ_DRIVE,
    input wire logic [3:0] DQ_IE,
    input wire logic RX_VALID,
    input wire logic TX_TAKEN,
    input wire logic ARMED,
    input wire logic PAUSED,
    input wire logic ACTIVE_POWER,
    input wire logic STANDBY_POWER,
    input wire logic IN_RESET,
    input wire sfpi_proto_t PROTOCOL_IN_USE
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_ie_not_oe: assert property (DQ_IE == ~DQ_DRIVE.oe)
        else $error("receiver enable not inverse of drive");
    a_desel_quiet: assert property (SEL_N_PIN [*6] |-> DQ_DRIVE.oe == 4'h0)
        else $error("lines driven while deselected");
    a_hwrst_quiet: assert property (!RESET_N_PIN [*6] |-> IN_RESET && DQ_DRIVE.oe == 4'h0)
        else $error("reset pin low without reset state");
    a_unarmed_mute: assert property (!ARMED |-> !RX_VALID && !TX_TAKEN)
        else $error("traffic before first select fall");
    a_idle_standby: assert property ((SEL_N_PIN && RESET_N_PIN && !BUSY &&
        !(DQ3_RESET_ENABLE && !DQ_IN[3])) [*8] |-> STANDBY_POWER)
        else $error("idle without standby");
    a_line3_reset: assert property ((DQ3_RESET_ENABLE && SEL_N_PIN && !DQ_IN[3]) [*6]
        |-> IN_RESET && DQ_DRIVE.oe == 4'h0)
        else $error("line 3 reset ignored while deselected");
    a_busy_awake: assert property (BUSY |=> !STANDBY_POWER)
        else $error("standby during internal cycle");
    a_rx_in_frame: assert property (RX_VALID |-> ACTIVE_POWER && !PAUSED ##1 !RX_VALID)
        else $error("byte outside an active frame");
    a_pause_quiet: assert property (PAUSED [*2] |-> !DQ_DRIVE.oe[1])
        else $error("line 1 driven in pause");
    a_boost_single: assert property ((BOOST_SUPPLY_HIGH && PROTOCOL == SFPI_PROTO_QUAD) [*3]
        |-> PROTOCOL_IN_USE == SFPI_PROTO_SINGLE)
        else $error("no single-line fallback under boost");
    a_quad_resume: assert property ((!BOOST_SUPPLY_HIGH && PROTOCOL == SFPI_PROTO_QUAD) [*3]
        |-> PROTOCOL_IN_USE == SFPI_PROTO_QUAD)
        else $error("quad not resumed");

    c_rx: cover property (RX_VALID);
    c_tx: cover property (TX_TAKEN);
    c_pause: cover property (PAUSED);
endmodule : sfpi_props

bind sfpi_pins sfpi_props i_sfpi_props (.CLK, .RST, .SEL_N_PIN, .RESET_N_PIN, .PROTOCOL,
    .BOOST_SUPPLY_HIGH, .BUSY, .DQ3_RESET_ENABLE, .DQ_IN, .DQ_DRIVE, .DQ_IE, .RX_VALID,
    .TX_TAKEN, .ARMED, .PAUSED,
    .ACTIVE_POWER, .STANDBY_POWER, .IN_RESET, .PROTOCOL_IN_USE);
`default_nettype wire

// ---- sim/tb_sfpi_pins.sv ----
// Purpose: self-checking bench for sfpi_pins
// Assumes: the bench plays the decoder and turns XFER to read after the command byte
// Notes: line 3 has a pull-up; other released lines toggle every CLK
`timescale 1ns/1ns
`default_nettype none
module tb_sfpi_pins;
    import sfpi_pkg::*;
    logic CLK = 1'b0;
    logic RST;
    logic RESET_N_PIN;
    logic PAUSE_ENABLE;
    logic DQ3_RESET_ENABLE;
    logic BOOST_SUPPLY_HIGH;
    logic BUSY;
    logic turn;
    logic hold3;
    logic tog = 1'b0;
    logic [7:0] TX_DATA;
    sfpi_proto_t PROTOCOL;
    sfpi_xfer_t XFER;
    sfpi_xfer_t rd_xfer;
    logic sclk, sel_n, TX_TAKEN, RX_VALID, ARMED, PAUSED, ACTIVE_POWER, STANDBY_POWER, IN_RESET;
    logic FRAME_START, FRAME_END;
    logic [3:0] h_do, h_oe, dq, DQ_IE;
    logic [7:0] RX_DATA, rx;
    sfpi_drive_t DQ_DRIVE;
    sfpi_proto_t PROTOCOL_IN_USE;
    int err_count = 0;
    int check_count = 0;
    int rx_n = 0;
    int tk_n = 0;
    int fs_n = 0;
    int fe_n = 0;

    always #10 CLK = ~CLK;
    always @(posedge CLK) tog <= ~tog;
    always @(posedge CLK) if (RX_VALID) rx_n <= rx_n + 1;
    always @(posedge CLK) if (TX_TAKEN) tk_n <= tk_n + 1;
    always @(posedge CLK) if (FRAME_START) fs_n <= fs_n + 1;
    always @(posedge CLK) if (FRAME_END) fe_n <= fe_n + 1;
    // turn round before the fall that launches the first read bit
    always @(posedge CLK) if (RX_VALID && turn) begin
        XFER <= rd_xfer;
        turn <= 1'b0;
    end
    assign dq = DQ_DRIVE.oe & DQ_DRIVE.dout | ~DQ_DRIVE.oe & (h_oe & h_do | ~h_oe & {~hold3, {3{tog}}});

    sfpi_host i_sfpi_host (.clk(CLK), .dq(dq), .sclk(sclk), .sel_n(sel_n), .dout(h_do), .oe(h_oe));
    sfpi_pins i_sfpi_pins (.CLK, .RST, .SCLK_PIN(sclk), .SEL_N_PIN(sel_n), .RESET_N_PIN,
        .DQ_IN(dq), .DQ_DRIVE, .DQ_IE, .PROTOCOL, .XFER, .PAUSE_ENABLE, .DQ3_RESET_ENABLE,
        .BOOST_SUPPLY_HIGH, .BUSY, .TX_DATA, .TX_TAKEN, .RX_DATA, .RX_VALID, .FRAME_START,
        .FRAME_END, .ARMED, .PAUSED, .ACTIVE_POWER, .STANDBY_POWER, .IN_RESET, .PROTOCOL_IN_USE);

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic t_unarmed;
        i_sfpi_host.xfer(1, 1'b0, 8'hC3, rx);
        check("armed", 8'(ARMED), 8'h00);
        check("rx count", 8'(rx_n), 8'h00);
        check("frames", 8'(fs_n), 8'h00);
        i_sfpi_host.sel(1'b1);
        $display("test unarmed done");
    endtask : t_unarmed

    task automatic t_write(input sfpi_proto_t p, input sfpi_width_t xw, input int w);
        PROTOCOL = p;
        XFER = '{width: xw, dir_out: 1'b0};
        BUSY = 1'b1;
        i_sfpi_host.sel(1'b0);
        check("active", 8'(ACTIVE_POWER), 8'h01);
        check("frame open", 8'(fs_n - fe_n), 8'h01);
        i_sfpi_host.xfer(w, 1'b0, 8'h96 ^ 8'(w), rx);
        check("rx data", RX_DATA, 8'h96 ^ 8'(w));
        i_sfpi_host.sel(1'b1);
        check("busy standby", 8'(STANDBY_POWER), 8'h00);
        check("drive", 8'(DQ_DRIVE.oe), 8'h00);
        check("frame closed", 8'(fs_n - fe_n), 8'h00);
        BUSY = 1'b0;
        i_sfpi_host.step(2);
        check("standby", 8'(STANDBY_POWER), 8'h01);
        $display("test write done");
    endtask : t_write

    task automatic t_read(input sfpi_proto_t p, input sfpi_width_t xw, input int cw, input int w);
        int t0;
        t0 = tk_n;
        PROTOCOL = p;
        XFER = '{width: SFPI_W1, dir_out: 1'b0};
        rd_xfer.width = xw;
        TX_DATA = 8'h5B ^ 8'(w);
        turn = 1'b1;
        i_sfpi_host.sel(1'b0);
        i_sfpi_host.xfer(cw, 1'b0, 8'h0B, rx);
        i_sfpi_host.xfer(w, 1'b1, 8'h00, rx);
        check("read data", rx, 8'h5B ^ 8'(w));
        i_sfpi_host.sel(1'b1);
        check("release", 8'(DQ_DRIVE.oe), 8'h00);
        // one fetch at the turn-round fall, one more at the fall after the last bit
        check("fetches", 8'(tk_n - t0), 8'h02);
        XFER.dir_out = 1'b0;
        $display("test read done");
    endtask : t_read

    task automatic t_pause;
        int n0;
        n0 = rx_n;
        PROTOCOL = SFPI_PROTO_SINGLE;
        PAUSE_ENABLE = 1'b1;
        i_sfpi_host.sel(1'b0);
        hold3 = 1'b1;
        i_sfpi_host.step(5);
        check("paused", 8'(PAUSED), 8'h01);
        i_sfpi_host.xfer(1, 1'b0, 8'h3C, rx);
        hold3 = 1'b0;
        i_sfpi_host.xfer(1, 1'b0, 8'hC3, rx);
        check("pause count", 8'(rx_n - n0), 8'h01);
        check("pause data", RX_DATA, 8'hC3);
        PROTOCOL = SFPI_PROTO_QUAD;
        DQ3_RESET_ENABLE = 1'b1;
        hold3 = 1'b1;
        i_sfpi_host.step(5);
        check("quad pause", 8'(PAUSED), 8'h00);
        check("quad reset", 8'(IN_RESET), 8'h00);
        hold3 = 1'b0;
        PAUSE_ENABLE = 1'b0;
        i_sfpi_host.sel(1'b1);
        hold3 = 1'b1;
        i_sfpi_host.step(5);
        check("line3 reset", 8'(IN_RESET), 8'h01);
        hold3 = 1'b0;
        i_sfpi_host.step(5);
        check("line3 reset left", 8'(IN_RESET), 8'h00);
        DQ3_RESET_ENABLE = 1'b0;
        $display("test pause done");
    endtask : t_pause

    task automatic t_hwreset;
        i_sfpi_host.sel(1'b0);
        // kept clear of internal cycles, BUSY stays low here
        RESET_N_PIN = 1'b0;
        i_sfpi_host.step(5);
        check("in reset", 8'(IN_RESET), 8'h01);
        check("reset active", 8'(ACTIVE_POWER), 8'h00);
        RESET_N_PIN = 1'b1;
        i_sfpi_host.sel(1'b1);
        check("reset left", 8'(IN_RESET), 8'h00);
        PROTOCOL = SFPI_PROTO_QUAD;
        BOOST_SUPPLY_HIGH = 1'b1;
        i_sfpi_host.step(3);
        check("boost", 8'(PROTOCOL_IN_USE), 8'(SFPI_PROTO_SINGLE));
        BOOST_SUPPLY_HIGH = 1'b0;
        i_sfpi_host.step(3);
        check("resume", 8'(PROTOCOL_IN_USE), 8'(SFPI_PROTO_QUAD));
        $display("test reset and boost done");
    endtask : t_hwreset

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        RST = 1'b1;
        RESET_N_PIN = 1'b1;
        PAUSE_ENABLE = 1'b0;
        DQ3_RESET_ENABLE = 1'b0;
        BOOST_SUPPLY_HIGH = 1'b0;
        BUSY = 1'b0;
        turn = 1'b0;
        hold3 = 1'b0;
        TX_DATA = 8'h00;
        PROTOCOL = SFPI_PROTO_SINGLE;
        XFER = '{width: SFPI_W1, dir_out: 1'b0};
        rd_xfer = '{width: SFPI_W1, dir_out: 1'b1};
        i_sfpi_host.init();
        i_sfpi_host.sel(1'b0);
        i_sfpi_host.step(12);
        RST = 1'b0;
        t_unarmed();
        t_write(SFPI_PROTO_SINGLE, SFPI_W1, 1);
        t_write(SFPI_PROTO_SINGLE, SFPI_W2, 2);
        t_write(SFPI_PROTO_DUAL, SFPI_W1, 2);
        t_write(SFPI_PROTO_QUAD, SFPI_W1, 4);
        t_read(SFPI_PROTO_SINGLE, SFPI_W1, 1, 1);
        t_read(SFPI_PROTO_SINGLE, SFPI_W2, 1, 2);
        t_read(SFPI_PROTO_SINGLE, SFPI_W4, 1, 4);
        t_read(SFPI_PROTO_QUAD, SFPI_W1, 4, 4);
        t_pause();
        t_hwreset();
        complete_run();
    end

    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule : tb_sfpi_pins
`default_nettype wire
